/* File: core/spip_consts.svh */
`ifndef SPIP_CONSTS_SVH
`define SPIP_CONSTS_SVH
// word lengths and counter widths
`define SPIP_WORD_W 16
`define SPIP_LEN8 5'h08
`define SPIP_LEN16 5'h10
`define SPIP_BAUD_MIN 16'h0002
`define SPIP_CNT_W 16
`define SPIP_SEL_N 7
`define SPIP_SEL_IDLE 7'h7f
`define SPIP_ZERO_WORD 16'h0000
`endif

/* File: core/spip_pkg.sv */
package spip_pkg;
   typedef enum logic [1:0] {
      SPIP_IDLE = 2'b00,
      SPIP_LOAD = 2'b01,
      SPIP_SHIFT = 2'b10,
      SPIP_DONE = 2'b11
   } spip_state_t;
endpackage

/* File: core/spip_buf2.sv */
`timescale 1ns/1ps
`include "spip_consts.svh"
module spip_buf2
   import spip_pkg::*;
(
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [`SPIP_WORD_W-1:0] in_data_in,
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [`SPIP_WORD_W-1:0] out_data_out
);
   logic [`SPIP_WORD_W-1:0] mem [0:1];
   logic [`SPIP_WORD_W-1:0] next_mem [0:1];
   logic [1:0] count;
   logic [1:0] next_count;
   logic push;
   logic pop;

   // two slots, head always in slot 0 so the output is a flop
   always_comb begin
      push = in_valid_in && in_ready_out;
      pop = out_valid_out && out_ready_in;
      next_mem[0] = mem[0];
      next_mem[1] = mem[1];
      next_count = count;
      if (pop) begin
         next_mem[0] = mem[1];
      end
      if (push) begin
         if (count == 2'h0 || (count == 2'h1 && pop)) begin
            next_mem[0] = in_data_in;
         end else begin
            next_mem[1] = in_data_in;
         end
      end
      next_count = 2'(count + {1'b0, push} - {1'b0, pop});
   end

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         count <= 2'h0;
         mem[0] <= `SPIP_ZERO_WORD;
         mem[1] <= `SPIP_ZERO_WORD;
      end else begin
         count <= next_count;
         mem[0] <= next_mem[0];
         mem[1] <= next_mem[1];
      end
   end

   assign in_ready_out = (count != 2'h2);
   assign out_valid_out = (count != 2'h0);
   assign out_data_out = mem[0];
endmodule

/* File: core/spip_port.sv */
`timescale 1ns/1ps
`include "spip_consts.svh"
module spip_port
   import spip_pkg::*;
(
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic enable_in,
   input wire logic master_in,
   input wire logic word16_in,
   input wire logic cpol_in,
   input wire logic cpha_in,
   input wire logic [15:0] baud_in,
   input wire logic [6:0] select_mask_in,
   input wire logic dma_enable_in,
   input wire logic [15:0] dma_count_in,
   input wire logic dma_count_load_in,
   input wire logic dma_irq_on_done_in,
   input wire logic tx_valid_in,
   output logic tx_ready_out,
   input wire logic [15:0] tx_data_in,
   output logic rx_valid_out,
   input wire logic rx_ready_in,
   output logic [15:0] rx_data_out,
   output logic dma_request_out,
   output logic word_irq_out,
   output logic dma_done_irq_out,
   output logic busy_out,
   output logic overflow_out,
   output logic sck_out,
   output logic sck_oe_out,
   input wire logic sck_in,
   output logic mosi_out,
   output logic mosi_oe_out,
   input wire logic mosi_in,
   output logic miso_out,
   output logic miso_oe_out,
   input wire logic miso_in,
   input wire logic slave_select_in,
   output logic [6:0] slave_select_out
);
   // two-flop synchronisers for pins; stage one read only by stage two
   logic [3:0] sync1;
   logic [3:0] sync2;
   // mosi changes only on the non-sampling edge, so a far slave never races it
   logic mosi_q;
   logic s_sck;
   logic s_mosi;
   logic s_miso;
   logic s_sel;
   logic sck_prev;

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         sync1 <= 4'hf;
         sync2 <= 4'hf;
         sck_prev <= 1'b0;
      end else begin
         sync1 <= {slave_select_in, sck_in, mosi_in, miso_in};
         sync2 <= sync1;
         sck_prev <= sync2[2];
      end
   end
   assign s_sel = sync2[3];
   assign s_sck = sync2[2];
   assign s_mosi = sync2[1];
   assign s_miso = sync2[0];

   spip_state_t state;
   spip_state_t next_state;
   logic [15:0] shreg;
   logic [15:0] next_shreg;
   logic [4:0] bits;
   logic [4:0] next_bits;
   logic [15:0] div;
   logic [15:0] next_div;
   logic sck_int;
   logic next_sck_int;
   logic half;
   logic next_half;
   logic next_mosi;
   logic [15:0] dcount;
   logic [15:0] next_dcount;
   logic rx_push;
   logic [15:0] rx_word;
   logic rx_buf_ready;
   logic [15:0] tx_word;
   logic tx_buf_valid;
   logic tx_pop;
   logic word_pulse;
   logic dma_done;
   logic ovf;
   logic next_ovf;
   logic [4:0] len;
   logic [15:0] baud_eff;
   logic lead_edge;
   logic trail_edge;
   logic slave_on;
   logic master_on;
   logic master_go;
   logic dma_live;

   // transmit and receive each pass a two-entry buffer so a master-mode stall loses nothing
   spip_buf2 u_txbuf (
      .clock_in(clock_in),
      .rst_n_in(rst_n_in),
      .in_valid_in(tx_valid_in),
      .in_ready_out(tx_ready_out),
      .in_data_in(tx_data_in),
      .out_valid_out(tx_buf_valid),
      .out_ready_in(tx_pop),
      .out_data_out(tx_word)
   );
   spip_buf2 u_rxbuf (
      .clock_in(clock_in),
      .rst_n_in(rst_n_in),
      .in_valid_in(rx_push),
      .in_ready_out(rx_buf_ready),
      .in_data_in(rx_word),
      .out_valid_out(rx_valid_out),
      .out_ready_in(rx_ready_in),
      .out_data_out(rx_data_out)
   );

   assign len = word16_in ? `SPIP_LEN16 : `SPIP_LEN8;
   // divider below two would exceed clock over four, so it is clamped
   assign baud_eff = (baud_in < `SPIP_BAUD_MIN) ? `SPIP_BAUD_MIN : baud_in;
   assign master_on = enable_in && master_in;
   assign slave_on = enable_in && !master_in && !s_sel;
   assign dma_live = dma_enable_in && (dcount != 16'h0000);
   // master waits for a word, a live dma count when dma is on, and room in receive
   assign master_go = master_on && tx_buf_valid && rx_buf_ready && (!dma_enable_in || dma_live);
   // slave edges: leading edge is the one leaving idle polarity
   assign lead_edge = slave_on && (s_sck != sck_prev) && (s_sck != cpol_in);
   assign trail_edge = slave_on && (s_sck != sck_prev) && (s_sck == cpol_in);

   // main shifter state
   always_comb begin
      next_state = state;
      next_shreg = shreg;
      next_bits = bits;
      next_div = div;
      next_sck_int = sck_int;
      next_half = half;
      next_mosi = mosi_q;
      next_dcount = dcount;
      next_ovf = ovf;
      tx_pop = 1'b0;
      rx_push = 1'b0;
      word_pulse = 1'b0;
      dma_done = 1'b0;
      if (dma_count_load_in) begin
         next_dcount = dma_count_in; // software queues a new count
      end
      case (state)
         SPIP_IDLE: begin
            next_sck_int = cpol_in;
            next_half = 1'b0;
            next_bits = 5'h00;
            // half still set from done keeps two idle clocks between master words
            if (master_go && !half) begin
               tx_pop = 1'b1;
               next_mosi = word16_in ? tx_word[15] : tx_word[7];
               next_shreg = word16_in ? tx_word : {tx_word[7:0], 8'h00};
               next_div = 16'h0000;
               next_state = SPIP_SHIFT;
            end else if (slave_on) begin
               // no word ready: send zeros rather than stale data
               tx_pop = tx_buf_valid;
               next_shreg = tx_buf_valid ? (word16_in ? tx_word : {tx_word[7:0], 8'h00})
                                         : `SPIP_ZERO_WORD;
               next_state = SPIP_LOAD;
            end
         end
         SPIP_LOAD: begin
            // slave: with cpha 1 the first leading edge shifts, with 0 it samples
            if (!slave_on) begin
               next_state = SPIP_IDLE;
            end else if (lead_edge) begin
               if (cpha_in) begin
                  next_half = 1'b1;
               end else begin
                  next_shreg = {shreg[14:0], s_mosi};
                  next_bits = 5'(bits + 5'h01);
               end
               next_state = SPIP_SHIFT;
            end
         end
         SPIP_SHIFT: begin
            if (master_on) begin
               // master: toggle sck every baud count of clocks
               if (div == 16'(baud_eff - 16'h0001)) begin
                  next_div = 16'h0000;
                  next_sck_int = !sck_int;
                  next_half = !half;
                  // sample on first half with cpha 0, second half with cpha 1
                  if (half == cpha_in) begin
                     next_shreg = {shreg[14:0], s_miso};
                     next_bits = 5'(bits + 5'h01);
                  end else begin
                     next_mosi = shreg[15];
                  end
                  if (half && next_bits == len) begin
                     next_state = SPIP_DONE;
                  end
               end else begin
                  next_div = 16'(div + 16'h0001);
               end
            end else if (!slave_on) begin
               next_state = SPIP_IDLE; // deselect aborts the word
            end else if (lead_edge || trail_edge) begin
               if ((lead_edge && !cpha_in) || (trail_edge && cpha_in)) begin
                  next_shreg = {shreg[14:0], s_mosi};
                  next_bits = 5'(bits + 5'h01);
                  if (bits == 5'(len - 5'h01)) begin
                     next_state = SPIP_DONE;
                  end
               end
            end
         end
         SPIP_DONE: begin
            // word complete: push to receive, count dma, raise events
            rx_push = 1'b1;
            next_ovf = ovf || !rx_buf_ready;
            word_pulse = 1'b1;
            if (dma_enable_in && dcount != 16'h0000) begin
               next_dcount = 16'(dcount - 16'h0001);
               dma_done = (dcount == 16'h0001);
            end
            next_sck_int = cpol_in;
            next_half = 1'b1;
            next_state = SPIP_IDLE;
         end
         default: begin
            next_state = SPIP_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         state <= SPIP_IDLE;
         shreg <= `SPIP_ZERO_WORD;
         bits <= 5'h00;
         div <= 16'h0000;
         sck_int <= 1'b0;
         half <= 1'b0;
         mosi_q <= 1'b0;
         dcount <= 16'h0000;
         ovf <= 1'b0;
      end else begin
         state <= next_state;
         shreg <= next_shreg;
         bits <= next_bits;
         div <= next_div;
         sck_int <= next_sck_int;
         half <= next_half;
         mosi_q <= next_mosi;
         dcount <= next_dcount;
         ovf <= next_ovf;
      end
   end

   assign rx_word = word16_in ? shreg : {8'h00, shreg[7:0]};

   // event outputs registered, one-cycle pulses
   logic word_irq;
   logic dma_irq;
   logic dma_req;
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         word_irq <= 1'b0;
         dma_irq <= 1'b0;
         dma_req <= 1'b0;
      end else begin
         word_irq <= word_pulse && !dma_enable_in;
         dma_irq <= dma_done && dma_irq_on_done_in;
         dma_req <= word_pulse && dma_enable_in;
      end
   end
   assign word_irq_out = word_irq;
   assign dma_done_irq_out = dma_irq;
   assign dma_request_out = dma_req;
   assign overflow_out = ovf;
   assign busy_out = (state != SPIP_IDLE);

   // pins: master drives sck and mosi; selected slave drives miso
   assign sck_out = sck_int;
   assign sck_oe_out = master_on;
   assign mosi_out = mosi_q;
   assign mosi_oe_out = master_on;
   assign miso_out = shreg[15];
   assign miso_oe_out = slave_on;
   // select outputs active low, several may be low together for broadcast
   assign slave_select_out = master_on ? ~select_mask_in : `SPIP_SEL_IDLE;
endmodule

/* File: tb/spip_port_asserts.sv */
`timescale 1ns/1ps
module spip_port_asserts (
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic enable_in,
   input wire logic master_in,
   input wire logic cpol_in,
   input wire logic [6:0] select_mask_in,
   input wire logic dma_enable_in,
   input wire logic dma_irq_on_done_in,
   input wire logic rx_valid_out,
   input wire logic word_irq_out,
   input wire logic dma_request_out,
   input wire logic dma_done_irq_out,
   input wire logic busy_out,
   input wire logic overflow_out,
   input wire logic sck_out,
   input wire logic sck_oe_out,
   input wire logic mosi_oe_out,
   input wire logic miso_oe_out,
   input wire logic slave_select_in,
   input wire logic [6:0] slave_select_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);
   // steady configuration long enough for synced and registered outputs to follow
   sequence s_master_steady;
      (master_in && enable_in && $stable(select_mask_in))[*3];
   endsequence
   sequence s_slave_idle;
      (!master_in && slave_select_in)[*4];
   endsequence
   sequence s_gap;
      !busy_out ##1 !busy_out;
   endsequence
   chk_sel_mask: assert property (s_master_steady |-> slave_select_out == ~select_mask_in)
      else $error("select outputs differ from mask");
   chk_sel_idle: assert property ((!master_in)[*3] |-> slave_select_out == 7'h7f)
      else $error("select outputs driven outside master mode");
   chk_miso_float: assert property (s_slave_idle |-> !miso_oe_out)
      else $error("miso driven while deselected");
   chk_master_oe: assert property (master_in && enable_in |-> sck_oe_out && mosi_oe_out)
      else $error("master lines not driven");
   chk_sck_rate: assert property (master_in && $changed(sck_out) |=> $stable(sck_out))
      else $error("sck faster than clock over four");
   chk_sck_idle: assert property ((master_in && !busy_out && $stable(cpol_in))[*3]
      |-> sck_out == cpol_in)
      else $error("sck idle level wrong");
   chk_word_gap: assert property (master_in && $fell(busy_out) |-> s_gap)
      else $error("master words too close");
   chk_word_irq: assert property (word_irq_out |-> !dma_request_out ##1 !word_irq_out)
      else $error("word interrupt not a lone pulse");
   chk_dma_req: assert property (dma_request_out |-> dma_enable_in ##1 !dma_request_out)
      else $error("dma request outside dma mode");
   chk_done_gate: assert property (dma_done_irq_out |-> dma_irq_on_done_in)
      else $error("done interrupt not requested");
   chk_dma_stop: assert property (dma_done_irq_out |=> (!busy_out)[*8])
      else $error("transfer after count reached zero");
   chk_rx_after: assert property ($rose(word_irq_out) |-> rx_valid_out || overflow_out)
      else $error("finished word not stored");
endmodule
bind spip_port spip_port_asserts i_spip_port_asserts (.*);

/* File: tb/spip_slave_model.sv */
`timescale 1ns/1ps
module spip_slave_model (
   input wire logic sck_in,
   input wire logic mosi_in,
   input wire logic sel_n_in,
   input wire logic cpol_in,
   input wire logic cpha_in,
   input wire logic word16_in,
   output logic miso_out,
   output logic [15:0] got_out
);
   logic [15:0] rep = 16'hc3a5;
   logic [15:0] sh = 16'h0000;
   int k = 0;
   // selection restarts a word; a released line shows the inverse of its last bit
   always @(sel_n_in) begin
      k = 0;
      miso_out = sel_n_in ? ~miso_out : rep[word16_in ? 15 : 7];
   end
   // echo: each word answers with the previous word received, so order shows
   always @(sck_in) begin
      if (!sel_n_in) begin
         if ((sck_in != cpol_in) != cpha_in) begin
            sh = {sh[14:0], mosi_in};
            k = k + 1;
            if (k == (word16_in ? 16 : 8)) begin
               k = 0;
               got_out = sh;
               rep = word16_in ? sh : {8'h00, sh[7:0]};
            end
         end else begin
            miso_out = rep[(word16_in ? 15 : 7) - k];
         end
      end
   end
endmodule

/* File: tb/spip_port_tb_top.sv */
`timescale 1ns/1ps
module spip_port_tb_top;
   logic clock_in = 0, rst_n_in = 0, enable_in = 1, master_in = 1;
   logic word16_in = 0, cpol_in = 0, cpha_in = 0, dma_enable_in = 0;
   logic dma_count_load_in = 0, dma_irq_on_done_in = 1, tx_valid_in = 0;
   logic rx_ready_in = 0, sck_in = 0, mosi_in = 0, slave_select_in = 1;
   logic [15:0] baud_in = 16'h0008, dma_count_in = 16'h0002, tx_data_in = 16'h0000;
   logic [6:0] select_mask_in = 7'h00;
   logic tx_ready_out, rx_valid_out, dma_request_out, word_irq_out, dma_done_irq_out;
   logic busy_out, overflow_out, sck_out, sck_oe_out, mosi_out, mosi_oe_out;
   logic miso_out, miso_oe_out, miso_in;
   logic [15:0] rx_data_out, got, msk, ms;
   logic [15:0] prev = 16'hc3a5;
   logic [7:0] sw = 8'h96;
   logic [6:0] slave_select_out;
   int n_errors = 0, total_checks = 0, cyc = 0, n_req = 0, n_done = 0;
   assign msk = word16_in ? 16'hffff : 16'h00ff;
   spip_port i_spip_port (.*);
   spip_slave_model i_spip_slave_model (.sck_in(sck_out), .mosi_in(mosi_out),
      .sel_n_in(slave_select_out[0]), .cpol_in(cpol_in), .cpha_in(cpha_in),
      .word16_in(word16_in), .miso_out(miso_in), .got_out(got));
   initial forever #20 clock_in = ~clock_in;
   // pulse counters and a watchdog well above the expected run length
   always @(posedge clock_in) begin
      cyc <= cyc + 1;
      n_req <= n_req + dma_request_out;
      n_done <= n_done + dma_done_irq_out;
      if (cyc == 20000) begin
         n_errors++;
         complete_run();
      end
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic clk(input int n);
      repeat (n) @(negedge clock_in);
   endtask
   // ready is settled at the falling edge, so the word goes at the next rise
   task automatic put(input logic [15:0] d);
      clk(1);
      tx_data_in = d;
      tx_valid_in = 1;
      while (!tx_ready_out) clk(1);
      clk(1);
      tx_valid_in = 0;
   endtask
   task automatic get(input logic [15:0] e, input bit c);
      clk(1);
      while (rx_valid_out !== 1'b1) clk(1);
      if (c) chk(rx_data_out & msk, e & msk);
      rx_ready_in = 1;
      clk(1);
      rx_ready_in = 0;
   endtask
   // deselect while the format changes, so the slave sees no stray sck edge
   task automatic xfer(input logic [2:0] m, input logic [15:0] t);
      clk(1);
      select_mask_in = 7'h00;
      {word16_in, cpol_in, cpha_in} = m;
      clk(4);
      select_mask_in = 7'h01;
      clk(4);
      put(t);
      get(prev, baud_in != 16'h0000);
      chk(got & msk, t & msk);
      prev = t & msk;
   endtask
   task automatic sbit(input logic b);
      mosi_in = b;
      clk(8);
      sck_in = 1;
      ms = {ms[14:0], miso_out};
      clk(8);
      sck_in = 0;
   endtask
   initial begin
      clk(4);
      rst_n_in = 1;
      for (int i = 0; i < 8; i++) xfer(i[2:0], 16'h9e37 ^ {i[7:0], 8'h5b});
      select_mask_in = 7'h55;
      clk(4);
      chk({9'h000, slave_select_out}, 16'h002a);
      baud_in = 16'h0000;
      xfer(3'b100, 16'h6b1d);
      baud_in = 16'h0008;
      dma_enable_in = 1;
      dma_count_load_in = 1;
      clk(1);
      dma_count_load_in = 0;
      for (int i = 0; i < 4; i++) put(16'h0071 + i[15:0]);
      while (n_done == 0) clk(1);
      clk(20);
      chk(16'(n_req), 16'h0002);
      chk(16'(n_done), 16'h0001);
      chk({14'h0000, busy_out, tx_ready_out}, 16'h0000);
      dma_enable_in = 0;
      for (int i = 0; i < 4; i++) get(i == 0 ? prev : 16'h0070 + i[15:0], 1);
      master_in = 0;
      word16_in = 0;
      clk(8);
      repeat (8) sbit(1'b1);
      chk({14'h0000, miso_oe_out, rx_valid_out}, 16'h0000);
      slave_select_in = 0;
      clk(8);
      ms = 16'hffff;
      for (int i = 7; i >= 0; i--) sbit(sw[i]);
      clk(8);
      chk({15'h0000, miso_oe_out}, 16'h0001);
      slave_select_in = 1;
      get(16'h0096, 1);
      chk(ms, 16'hff00);
      complete_run();
   end
endmodule
